// ===== logic/fiv_top.v
// fast interrupt vectoring: registers, arbitration and vector address to the core
`timescale 1ns/1ns
`include "fiv_defines.vh"

// Notes on behaviour
// - fast0_vector_addr_low holds the low 16 bits of the fast 0 service address.
// - fast0_vector_addr_high bits 4..0 hold the top five bits of the fast 0 address.
// - unused upper bits of the high and select registers read zero and ignore writes.
// - fast1_source_select bits 5..0 name the source handled as fast interrupt 1.
// - a taken fast interrupt hands the core its own service address, no jump table.
// - a fast source beats every non-fast level-2 request regardless of table position.
// - with both fast interrupts pending, fast interrupt 0 is served first.
// - fast1_vector_addr_low holds the low 16 bits of the fast 1 service address.
// - fast0_source_select bits 5..0 name the source handled as fast interrupt 0.
// - fast1_vector_addr_high bits 4..0 hold the top five bits of the fast 1 address.
// - other interrupts get the 14-bit vector base above a 7-bit vector number.
module fiv_top #(
    parameter NUM_IRQ = 64,
    parameter ADDR_W = 8
) (
    // clock, reset, enable
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    // avalon-mm slave
    input wire [ADDR_W-1:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output wire [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    // interrupt sources
    input wire [NUM_IRQ-1:0] irq_pending_in,
    input wire [NUM_IRQ-1:0] irq_level2_in,
    input wire ext_req_in,
    input wire [6:0] ext_vec_in,
    // core side
    input wire core_ack_in,
    output wire core_irq_out,
    output wire [20:0] vector_address_output_out,
    output wire fast0_active_out,
    output wire fast1_active_out
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] wdata;
        input [3:0] be;
        begin
            merge16 = old;
            if (be[0]) begin
                merge16[7:0] = wdata[7:0];
            end
            if (be[1]) begin
                merge16[15:8] = wdata[15:8];
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg [`FIV_VBASE_MSB:0] vector_base_q;
    reg [`FIV_SEL_MSB:0] fast0_source_select_q;
    reg [`FIV_LOW_MSB:0] fast0_vector_addr_low_q;
    reg [`FIV_HIGH_MSB:0] fast0_vector_addr_high_q;
    reg [`FIV_SEL_MSB:0] fast1_source_select_q;
    reg [`FIV_LOW_MSB:0] fast1_vector_addr_low_q;
    reg [`FIV_HIGH_MSB:0] fast1_vector_addr_high_q;

    reg [`FIV_NUM_MSB:0] taken_num_q;
    reg taken_fast0_q;
    reg taken_fast1_q;

    reg ack_q;
    reg [31:0] rdata_q;

    reg irq_q;
    reg [`FIV_ADDR_MSB:0] vector_q;
    reg fast0_q;
    reg fast1_q;
    reg [`FIV_NUM_MSB:0] num_q;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire [5:0] reg_idx = avs_address_in[7:2];
    wire bus_req = avs_read_in | avs_write_in;
    wire wr_go = avs_write_in & ack_q & ce_in;

    // one wait cycle, answer on the second cycle of a request
    assign avs_waitrequest_out = bus_req & ~ack_q;
    assign avs_readdata_out = rdata_q;

    always @(posedge clk_in) begin
        if (rst_in) begin
            ack_q <= 1'b0;
        end else if (ce_in) begin
            ack_q <= bus_req & ~ack_q;
        end
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    wire [15:0] wr_vbase = merge16({2'b00, vector_base_q}, avs_writedata_in,
                                   avs_byteenable_in);
    wire [15:0] wr_sel0 = merge16({10'h000, fast0_source_select_q}, avs_writedata_in,
                                  avs_byteenable_in);
    wire [15:0] wr_low0 = merge16(fast0_vector_addr_low_q, avs_writedata_in,
                                  avs_byteenable_in);
    wire [15:0] wr_high0 = merge16({11'h000, fast0_vector_addr_high_q}, avs_writedata_in,
                                   avs_byteenable_in);
    wire [15:0] wr_sel1 = merge16({10'h000, fast1_source_select_q}, avs_writedata_in,
                                  avs_byteenable_in);
    wire [15:0] wr_low1 = merge16(fast1_vector_addr_low_q, avs_writedata_in,
                                  avs_byteenable_in);
    wire [15:0] wr_high1 = merge16({11'h000, fast1_vector_addr_high_q}, avs_writedata_in,
                                   avs_byteenable_in);

    always @(posedge clk_in) begin
        if (rst_in) begin
            vector_base_q <= `FIV_RST_VBASE;
            fast0_source_select_q <= `FIV_RST_SEL;
            fast0_vector_addr_low_q <= `FIV_RST_LOW;
            fast0_vector_addr_high_q <= `FIV_RST_HIGH;
            fast1_source_select_q <= `FIV_RST_SEL;
            fast1_vector_addr_low_q <= `FIV_RST_LOW;
            fast1_vector_addr_high_q <= `FIV_RST_HIGH;
        end else if (wr_go) begin
            case (reg_idx)
                `FIV_IDX_VECTOR_BASE: begin
                    vector_base_q <= wr_vbase[`FIV_VBASE_MSB:0];
                end
                `FIV_IDX_FAST0_SEL: begin
                    fast0_source_select_q <= wr_sel0[`FIV_SEL_MSB:0];
                end
                `FIV_IDX_FAST0_LOW: begin
                    fast0_vector_addr_low_q <= wr_low0;
                end
                `FIV_IDX_FAST0_HIGH: begin
                    fast0_vector_addr_high_q <= wr_high0[`FIV_HIGH_MSB:0];
                end
                `FIV_IDX_FAST1_SEL: begin
                    fast1_source_select_q <= wr_sel1[`FIV_SEL_MSB:0];
                end
                `FIV_IDX_FAST1_LOW: begin
                    fast1_vector_addr_low_q <= wr_low1;
                end
                `FIV_IDX_FAST1_HIGH: begin
                    fast1_vector_addr_high_q <= wr_high1[`FIV_HIGH_MSB:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------------
    reg [15:0] rd_val;

    always @* begin
        rd_val = 16'h0000;
        case (reg_idx)
            `FIV_IDX_VECTOR_BASE: begin
                rd_val = {2'b00, vector_base_q};
            end
            `FIV_IDX_FAST0_SEL: begin
                rd_val = {10'h000, fast0_source_select_q};
            end
            `FIV_IDX_FAST0_LOW: begin
                rd_val = fast0_vector_addr_low_q;
            end
            `FIV_IDX_FAST0_HIGH: begin
                rd_val = {11'h000, fast0_vector_addr_high_q};
            end
            `FIV_IDX_FAST1_SEL: begin
                rd_val = {10'h000, fast1_source_select_q};
            end
            `FIV_IDX_FAST1_LOW: begin
                rd_val = fast1_vector_addr_low_q;
            end
            `FIV_IDX_FAST1_HIGH: begin
                rd_val = {11'h000, fast1_vector_addr_high_q};
            end
            `FIV_IDX_STATUS: begin
                rd_val[`FIV_NUM_MSB:0] = taken_num_q;
                rd_val[`FIV_ST_FAST0_BIT] = taken_fast0_q;
                rd_val[`FIV_ST_FAST1_BIT] = taken_fast1_q;
                rd_val[`FIV_ST_PEND_BIT] = irq_q;
                rd_val[`FIV_ST_IRQ_BIT] = irq_q & ~core_ack_in;
            end
            default: begin
                rd_val = 16'h0000;
            end
        endcase
    end

    // read data captured in the wait cycle, stands in the answer cycle
    always @(posedge clk_in) begin
        if (rst_in) begin
            rdata_q <= 32'h00000000;
        end else if (ce_in && avs_read_in && !ack_q) begin
            rdata_q <= {16'h0000, rd_val};
        end
    end

    // ------------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------------
    wire arb_req;
    wire [6:0] arb_vec;
    wire arb_fast0;
    wire arb_fast1;

    // fast sources must be level 2 so that the promotion below applies
    fiv_arbiter #(
        .NUM_IRQ(NUM_IRQ)
    ) u_arb (
        .pending_in(irq_pending_in),
        .level2_in(irq_level2_in),
        .fast0_sel_in(fast0_source_select_q),
        .fast1_sel_in(fast1_source_select_q),
        .ext_req_in(ext_req_in),
        .ext_vec_in(ext_vec_in),
        .req_out(arb_req),
        .vec_out(arb_vec),
        .fast0_out(arb_fast0),
        .fast1_out(arb_fast1)
    );

    // ------------------------------------------------------------------
    // vector address forming
    // ------------------------------------------------------------------
    wire [`FIV_ADDR_MSB:0] fast0_addr = {fast0_vector_addr_high_q,
                                         fast0_vector_addr_low_q};
    wire [`FIV_ADDR_MSB:0] fast1_addr = {fast1_vector_addr_high_q,
                                         fast1_vector_addr_low_q};
    wire [`FIV_ADDR_MSB:0] base_addr = {vector_base_q, arb_vec};

    reg [`FIV_ADDR_MSB:0] vector_d;

    always @* begin
        vector_d = base_addr;
        if (arb_fast0) begin
            vector_d = fast0_addr;
        end else if (arb_fast1) begin
            vector_d = fast1_addr;
        end
    end

    always @(posedge clk_in) begin
        if (rst_in) begin
            irq_q <= 1'b0;
            vector_q <= `FIV_RST_VECTOR;
            fast0_q <= 1'b0;
            fast1_q <= 1'b0;
            num_q <= 7'h00;
        end else if (ce_in) begin
            irq_q <= arb_req;
            vector_q <= arb_req ? vector_d : `FIV_RST_VECTOR;
            fast0_q <= arb_fast0;
            fast1_q <= arb_fast1;
            num_q <= arb_vec;
        end
    end

    // ------------------------------------------------------------------
    // record of the interrupt last taken by the core
    // ------------------------------------------------------------------
    always @(posedge clk_in) begin
        if (rst_in) begin
            taken_num_q <= 7'h00;
            taken_fast0_q <= 1'b0;
            taken_fast1_q <= 1'b0;
        end else if (ce_in && core_ack_in && irq_q) begin
            // fast ones show the low address bits of the jump target
            taken_num_q <= (fast0_q | fast1_q) ? vector_q[`FIV_NUM_MSB:0] : num_q;
            taken_fast0_q <= fast0_q;
            taken_fast1_q <= fast1_q;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign core_irq_out = irq_q;
    assign vector_address_output_out = vector_q;
    assign fast0_active_out = fast0_q;
    assign fast1_active_out = fast1_q;

endmodule

// ===== logic/fiv_defines.vh
// register map, field layout and reset values of the fast interrupt vectoring block
`ifndef FIV_DEFINES_VH
`define FIV_DEFINES_VH

// ----------------------------------------------------------------------
// register indices; byte address is four times the index
// ----------------------------------------------------------------------
`define FIV_IDX_VECTOR_BASE 6'h05
`define FIV_IDX_FAST0_SEL 6'h06
`define FIV_IDX_FAST0_LOW 6'h07
`define FIV_IDX_FAST0_HIGH 6'h08
`define FIV_IDX_FAST1_SEL 6'h09
`define FIV_IDX_FAST1_LOW 6'h0a
`define FIV_IDX_FAST1_HIGH 6'h0b
`define FIV_IDX_STATUS 6'h0f

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FIV_LOW_MSB 15
`define FIV_HIGH_MSB 4
`define FIV_SEL_MSB 5
`define FIV_VBASE_MSB 13
`define FIV_NUM_MSB 6
`define FIV_ADDR_MSB 20
`define FIV_ST_FAST0_BIT 7
`define FIV_ST_FAST1_BIT 8
`define FIV_ST_PEND_BIT 14
`define FIV_ST_IRQ_BIT 15

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FIV_RST_LOW 16'h0000
`define FIV_RST_HIGH 5'h00
`define FIV_RST_SEL 6'h00
`define FIV_RST_VBASE 14'h0000
`define FIV_RST_VECTOR 21'h000000
`define FIV_RST_STATUS 16'h0000

`endif

// ===== logic/fiv_arbiter.v
// level-2 arbitration with fast interrupt promotion
`timescale 1ns/1ns
module fiv_arbiter #(
    parameter NUM_IRQ = 64
) (
    // request lines
    input wire [NUM_IRQ-1:0] pending_in,
    input wire [NUM_IRQ-1:0] level2_in,
    // fast interrupt selections
    input wire [5:0] fast0_sel_in,
    input wire [5:0] fast1_sel_in,
    // winner below level 2 from the rest of the controller
    input wire ext_req_in,
    input wire [6:0] ext_vec_in,
    // result
    output reg req_out,
    output reg [6:0] vec_out,
    output reg fast0_out,
    output reg fast1_out
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function is_fast;
        input [5:0] sel;
        input [NUM_IRQ-1:0] pend;
        input [NUM_IRQ-1:0] lvl2;
        begin
            is_fast = pend[sel] & lvl2[sel];
        end
    endfunction

    function [6:0] first_set;
        input [NUM_IRQ-1:0] vec;
        integer i;
        begin
            first_set = 7'h00;
            for (i = NUM_IRQ - 1; i >= 0; i = i - 1) begin
                if (vec[i]) begin
                    first_set = i[6:0];
                end
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------------
    wire [NUM_IRQ-1:0] lvl2_pend = pending_in & level2_in;
    wire hit0 = is_fast(fast0_sel_in, pending_in, level2_in);
    wire hit1 = is_fast(fast1_sel_in, pending_in, level2_in);

    always @* begin
        req_out = 1'b0;
        vec_out = 7'h00;
        fast0_out = 1'b0;
        fast1_out = 1'b0;
        if (hit0) begin
            req_out = 1'b1;
            vec_out = {1'b0, fast0_sel_in};
            fast0_out = 1'b1;
        end else if (hit1) begin
            req_out = 1'b1;
            vec_out = {1'b0, fast1_sel_in};
            fast1_out = 1'b1;
        end else if (|lvl2_pend) begin
            req_out = 1'b1;
            vec_out = first_set(lvl2_pend);
        end else if (ext_req_in) begin
            req_out = 1'b1;
            vec_out = ext_vec_in;
        end
    end

endmodule

// ===== bench/fiv_monitor.sv
// port checker for the fast interrupt vectoring block
`timescale 1ns/1ns
module fiv_monitor #(
    parameter NUM_IRQ = 64,
    parameter ADDR_W = 8
) (
    // clock and bus
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    input wire [ADDR_W-1:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    // interrupt side
    input wire [NUM_IRQ-1:0] irq_pending_in,
    input wire [NUM_IRQ-1:0] irq_level2_in,
    input wire ext_req_in,
    input wire [6:0] ext_vec_in,
    input wire core_ack_in,
    input wire core_irq_out,
    input wire [20:0] vector_address_output_out,
    input wire fast0_active_out,
    input wire fast1_active_out
);
// ----
// shadow registers from observed writes
// ----
reg [15:0] sh_q [5:11];
integer i;
wire [5:0] idx = avs_address_in[7:2];
wire [15:0] m = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
wire rd = ce_in && avs_read_in && !avs_waitrequest_out;
wire wr = ce_in && avs_write_in && !avs_waitrequest_out;
always @(posedge clk_in) begin
    for (i = 5; i < 12; i = i + 1) begin
        if (rst_in) sh_q[i] <= 16'h0000;
        else if (wr && idx == i) sh_q[i] <= (sh_q[i] & ~m) | (avs_writedata_in[15:0] & m);
    end
end
wire [NUM_IRQ-1:0] act = irq_pending_in & irq_level2_in;
wire f0 = act[sh_q[6][5:0]];
wire f1 = act[sh_q[9][5:0]];
wire [20:0] a0 = {sh_q[8][4:0], sh_q[7]};
wire [20:0] a1 = {sh_q[11][4:0], sh_q[10]};
wire [20:0] nb = {sh_q[5][13:0], ext_vec_in};
wire ok_idx = idx >= 6'h05 && idx <= 6'h0b;
wire [15:0] mk = idx == 6'h05 ? 16'h3fff : (idx == 6'h06 || idx == 6'h09) ? 16'h003f :
    (idx == 6'h08 || idx == 6'h0b) ? 16'h001f : 16'hffff;
wire [15:0] exp_rd = ok_idx ? sh_q[idx] & mk : 16'h0000;
// ----
// assertions
// ----
default clocking cb @(posedge clk_in); endclocking
default disable iff (rst_in);
AST_WAIT: assert property (($rose(avs_read_in) || $rose(avs_write_in)) && ce_in |->
    avs_waitrequest_out ##1 !avs_waitrequest_out) else $error("bus wait not one cycle");
AST_READ: assert property (rd && idx != 6'h0f |->
    avs_readdata_out == {16'h0000, exp_rd}) else $error("read data wrong");
AST_FAST0: assert property (f0 |=> fast0_active_out && !fast1_active_out &&
    vector_address_output_out == $past(a0)) else $error("fast 0 vector wrong");
AST_FAST1: assert property (f1 && !f0 |=> fast1_active_out &&
    vector_address_output_out == $past(a1)) else $error("fast 1 vector wrong");
AST_BOTH: assert property (f0 && f1 |=> !fast1_active_out)
    else $error("fast 1 served before fast 0");
AST_EXT: assert property (ext_req_in && act == '0 |=> core_irq_out &&
    vector_address_output_out == $past(nb)) else $error("base vector wrong");
AST_IDLE: assert property ((!ext_req_in && act == '0)[*2] |->
    !core_irq_out && vector_address_output_out == 21'h000000) else $error("idle vector");
AST_FLAG: assert property (fast0_active_out || fast1_active_out |-> core_irq_out)
    else $error("fast flag without request");
CV_BOTH: cover property (f0 && f1);
CV_EXT: cover property (ext_req_in && act == '0);
CV_RDHI: cover property (rd && idx == 6'h08);
endmodule

// ===== bench/fiv_core_model.sv
// core side model: takes each presented interrupt once, promptly or after a stall
`timescale 1ns/1ns
module fiv_core_model (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // stall cycles before taking
    input wire [3:0] stall_in,
    // interrupt handshake
    input wire irq_in,
    output reg ack_out
);
reg [3:0] cnt_q;
reg done_q;
always @(posedge clk_in) begin
    if (rst_in || !irq_in) begin
        cnt_q <= 4'h0;
        done_q <= 1'b0;
        ack_out <= 1'b0;
    end else begin
        cnt_q <= cnt_q + 4'h1;
        ack_out <= !done_q && cnt_q == stall_in;
        done_q <= done_q || cnt_q == stall_in;
    end
end
endmodule

// ===== bench/fiv_top_tb_top.sv
// self-checking bench of the fast interrupt vectoring block
`timescale 1ns/1ns
module fiv_top_tb_top;
reg clk_in = 1'b0;
reg rst_in = 1'b1;
reg ce_in = 1'b1;
reg [7:0] avs_address_in = 8'h00;
reg avs_read_in = 1'b0;
reg avs_write_in = 1'b0;
reg [31:0] avs_writedata_in = 32'h00000000;
reg [3:0] avs_byteenable_in = 4'h0;
reg [63:0] irq_pending_in = 64'h0;
reg [63:0] irq_level2_in = 64'h0;
reg ext_req_in = 1'b0;
reg [6:0] ext_vec_in = 7'h00;
reg [3:0] stall = 4'h0;
wire [31:0] avs_readdata_out;
wire avs_waitrequest_out, core_ack_in, core_irq_out, fast0_active_out, fast1_active_out;
wire [20:0] vector_address_output_out;
wire [31:0] seen_iv = {9'h000, fast0_active_out, fast1_active_out, vector_address_output_out};
integer seed, r, i;
integer n_fail = 0;
integer num_checks = 0;
reg [31:0] rn;
reg [15:0] wv [5:16];
reg [31:0] q_rd [$];
reg [31:0] q_iv [$];
reg [20:0] a0, a1;
reg [63:0] b0, b1;
always #25 clk_in = ~clk_in;
fiv_top DUT (.*);
fiv_core_model u_core (.clk_in(clk_in), .rst_in(rst_in), .stall_in(stall),
    .irq_in(core_irq_out), .ack_out(core_ack_in));
// ----
// tasks
// ----
task final_report;
    begin
        if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    end
endtask
task cmp(input [8*8:1] nm, input [31:0] e, input [31:0] s);
    begin
        num_checks = num_checks + 1;
        if (s !== e) begin
            n_fail = n_fail + 1;
            $display("Error %0s expected %h seen %h", nm, e, s);
        end
    end
endtask
task cmp_rd(input [31:0] e, input [31:0] s);
    begin
        cmp("readdata", e, s);
    end
endtask
task cmp_vec(input [31:0] e, input [31:0] s);
    begin
        cmp("vector", e, s);
    end
endtask
function [15:0] mk(input integer k);
    begin
        case (k)
            5: mk = 16'h3fff;
            6, 9: mk = 16'h003f;
            7, 10: mk = 16'hffff;
            8, 11: mk = 16'h001f;
            default: mk = 16'h0000;
        endcase
    end
endfunction
task bus(input logic w, input logic [5:0] a, input logic [15:0] d, input logic [3:0] b);
    integer t;
    begin
        t = 0;
        avs_address_in <= {a, 2'b00};
        avs_writedata_in <= {16'hffff, d};
        avs_byteenable_in <= b;
        avs_write_in <= w;
        avs_read_in <= !w;
        do begin
            @(posedge clk_in);
            t = t + 1;
        end while (avs_waitrequest_out !== 1'b0 && t < 20);
        if (t >= 20) cmp("timeout", 0, 1);
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge clk_in);
    end
endtask
task rd(input logic [5:0] a, input logic [15:0] e);
    begin
        q_rd.push_back({16'h0000, e});
        bus(1'b0, a, 16'h0000, 4'h3);
    end
endtask
task irq(input logic [63:0] p, input logic [63:0] l, input logic e, input logic [22:0] x);
    integer t;
    begin
        t = $random(seed);
        stall <= {2'b00, t[1:0]};
        t = 0;
        q_iv.push_back({9'h000, x});
        irq_pending_in <= p;
        irq_level2_in <= l;
        ext_req_in <= e;
        do begin
            @(posedge clk_in);
            t = t + 1;
        end while (core_ack_in !== 1'b1 && t < 40);
        if (t >= 40) cmp("timeout", 0, 1);
        irq_pending_in <= 64'h0;
        ext_req_in <= 1'b0;
        repeat (3) @(posedge clk_in);
    end
endtask
// ----
// result watcher
// ----
always @(posedge clk_in) begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0 && q_rd.size() > 0)
        cmp_rd(q_rd.pop_front(), avs_readdata_out);
    if (core_ack_in === 1'b1 && core_irq_out === 1'b1 && q_iv.size() > 0)
        cmp_vec(q_iv.pop_front(), seen_iv);
end
// ----
// main sequence
// ----
initial begin
    seed = 32'h75714984;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    for (i = 5; i < 17; i = i + 1) begin
        wv[i] = 16'h0000;
        rd(i[5:0], 16'h0000);
    end
    for (r = 0; r < 2; r = r + 1) begin
        rn = $random(seed);
        ext_vec_in <= rn[6:0];
        for (i = 5; i < 12; i = i + 1) begin
            rn = $random(seed);
            wv[i] = rn[15:0];
            if (i == 6) wv[i][5:4] = 2'b01;
            if (i == 9) wv[i][5:4] = 2'b11;
            bus(1'b1, i[5:0], wv[i], 4'h3);
        end
        bus(1'b1, 6'h10, 16'hffff, 4'h3);
        bus(1'b1, 6'h07, 16'hffc3, 4'h1);
        wv[7][7:0] = 8'hc3;
        for (i = 5; i < 17; i = i + 1)
            if (i != 15) rd(i[5:0], wv[i] & mk(i));
        a0 = {wv[8][4:0], wv[7]};
        a1 = {wv[11][4:0], wv[10]};
        b0 = 64'h1 << wv[6][5:0];
        b1 = 64'h1 << wv[9][5:0];
        irq(b0 | 64'h8, b0 | 64'h8, 1'b1, {2'b10, a0});
        rd(6'h0f, {7'h00, 2'b01, a0[6:0]});
        irq(b1 | 64'h8, b1 | 64'h8, 1'b0, {2'b01, a1});
        irq(b0 | b1, b0 | b1, 1'b0, {2'b10, a0});
        irq(64'h18, 64'h18, 1'b0, {2'b00, wv[5][13:0], 7'h03});
        irq(64'h0, 64'h0, 1'b1, {2'b00, wv[5][13:0], ext_vec_in});
        rd(6'h0f, {9'h000, ext_vec_in});
    end
    final_report;
end
initial begin
    #(50 * 5000);
    n_fail = n_fail + 1;
    final_report;
end
endmodule
bind fiv_top fiv_monitor #(.NUM_IRQ(NUM_IRQ), .ADDR_W(ADDR_W)) u_mon (.*);
